// *** pa_index_limit_table_ramp_shaper.sv ***
`timescale 1ns/1ps

// Overview of operation
// [RULE_01] table holds eight independent amplifier power codes
// [RULE_02] three-bit limit picks the steady transmit entry
// [RULE_03] ramp entries zero to limit at start, end; ASK and OOK skip the start ramp, OOK also skips the end ramp
// [RULE_04] limit zero means entry zero only, no ramp; on-off keying ignores the limit and drives entry one on a one symbol
// [RULE_05] on-off keying: entry zero low, entry one high
// [RULE_06] single access reaches entry zero; burst reaches others
// [RULE_07] sleep loses every entry except entry zero
// [RULE_08] reset loads entry zero with code C6
// [RULE_09] codes 61 to 6F are advised against
// [RULE_10] shaping counts up on one, down on zero
// [RULE_11] counter steps eight times per symbol period
// [RULE_12] counter saturates at limit and at zero
// [RULE_13] counter value indexes the table in ASK
// [RULE_14] software sets limit seven for full ASK shaping
// [RULE_15] shaping, ramping codes only 30-3F or 00
// [RULE_16] counter starts at zero, returns there after ramp
module pa_index_limit_table_ramp_shaper (
  input  wire logic                          core_clk_in,     // block clock, 200 MHz
  input  wire logic                          rst_in,          // synchronous reset, active high
  input  wire logic                          clk_en_in,       // freezes all state while low
  input  wire pa_ramp_pkg::table_access_type access_in,       // decoded serial table access
  input  wire pa_ramp_pkg::tx_ctrl_type      tx_in,           // modulator control and symbol
  input  wire logic                          step_tick_in,    // eight pulses per symbol period
  input  wire logic                          sleep_in,        // pulse: entering sleep
  output logic                         [7:0] pa_code_out,     // amplifier drive code
  output logic                         [2:0] drive_index_out, // table index in use
  output logic                               ramp_busy_out,   // ramp up or down in progress
  output logic                               tx_on_out,       // steady transmit level reached
  output logic                         [7:0] rd_data_out      // table read data
);

  // transmit envelope sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RAMP_UP,
    ST_ON,
    ST_RAMP_DOWN
  } env_state_type;

  env_state_type state;        // current envelope state
  env_state_type next_state;   // envelope state after this edge
  logic [2:0]    burst_ptr;    // entry reached by the next burst byte
  logic [2:0]    access_idx;   // entry the current byte reaches
  logic [2:0]    shape_count;  // shaping and ramping counter
  logic [2:0]    next_drive;   // index selected for the amplifier
  logic          cnt_clear;    // hold counter at zero
  logic          cnt_up;       // counter moves toward limit
  logic          cnt_down;     // counter moves toward zero
  logic [7:0]    rd_code;      // code at access index
  logic [7:0]    drv_code;     // code at selected drive index
  logic          is_ook;       // on-off keying selected
  logic          is_ask;       // amplitude shift keying selected

  // mode decode
  assign is_ook = (tx_in.mode == pa_ramp_pkg::MOD_OOK);
  assign is_ask = (tx_in.mode == pa_ramp_pkg::MOD_ASK);

  // ---------------- table access ----------------

  // burst pointer restarts at each access and advances per byte
  // a start cycle carries no byte, it only rewinds the pointer
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      burst_ptr <= pa_ramp_pkg::INDEX_ZERO;
    end else if (clk_en_in) begin
      if (access_in.start) begin
        burst_ptr <= pa_ramp_pkg::INDEX_ZERO;
      end else if (access_in.burst && (access_in.wr || access_in.rd)) begin
        burst_ptr <= burst_ptr + 3'h1; // wraps after the last entry
      end
    end
  end

  // a single access only ever reaches entry zero
  assign access_idx = access_in.burst ? burst_ptr : pa_ramp_pkg::INDEX_ZERO; // [RULE_06]

  // read data is registered on each read byte
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rd_data_out <= 8'h00;
    end else if (clk_en_in && access_in.rd && !access_in.start) begin
      rd_data_out <= rd_code;
    end
  end

  // power code storage with sleep loss and reset default
  pa_table_store #(
    .DEPTH (pa_ramp_pkg::TABLE_DEPTH)
  ) u_store (
    .core_clk_in  (core_clk_in),
    .rst_in       (rst_in),
    .clk_en_in    (clk_en_in),
    .sleep_in     (sleep_in),
    .wr_in        (access_in.wr && !access_in.start),
    .wr_idx_in    (access_idx),
    .wr_data_in   (access_in.data),
    .rd_idx_in    (access_idx),
    .drv_idx_in   (next_drive),
    .rd_code_out  (rd_code),
    .drv_code_out (drv_code)
  );

  // ---------------- envelope sequencing ----------------

  // next envelope state
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (tx_in.tx_active) begin
          // keying modes shape from zero themselves; others ramp
          next_state = (is_ook || is_ask) ? ST_ON : ST_RAMP_UP; // [RULE_16]
        end
      end
      ST_RAMP_UP: begin
        if (!tx_in.tx_active) begin
          next_state = ST_RAMP_DOWN;
        end else if (shape_count == tx_in.limit) begin // [RULE_04]
          next_state = ST_ON; // [RULE_03]
        end
      end
      ST_ON: begin
        if (!tx_in.tx_active) begin
          // on-off keying has no envelope to wind down
          next_state = is_ook ? ST_IDLE : ST_RAMP_DOWN; // [RULE_03]
        end
      end
      ST_RAMP_DOWN: begin
        if (shape_count == pa_ramp_pkg::INDEX_ZERO) begin
          next_state = ST_IDLE; // [RULE_16]
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // state register
  // a low enable keeps the envelope where it stands
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      state <= ST_IDLE;
    end else if (clk_en_in) begin
      state <= next_state;
    end
  end

  // counter direction from state, mode and symbol
  always_comb begin
    cnt_clear = 1'b0;
    cnt_up    = 1'b0;
    cnt_down  = 1'b0;
    case (state)
      ST_IDLE: begin
        cnt_clear = 1'b1; // [RULE_16]
      end
      ST_RAMP_UP: begin
        cnt_up = 1'b1; // [RULE_03]
      end
      ST_ON: begin
        // amplitude keying follows the symbol, others hold
        cnt_up   = is_ask && tx_in.symbol;  // [RULE_10]
        cnt_down = is_ask && !tx_in.symbol; // [RULE_10]
      end
      ST_RAMP_DOWN: begin
        cnt_down = 1'b1; // [RULE_03]
      end
      default: begin
        cnt_clear = 1'b1;
      end
    endcase
  end

  // saturating shaping counter
  pa_index_counter #(
    .WIDTH (pa_ramp_pkg::INDEX_WIDTH)
  ) u_counter (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .clk_en_in   (clk_en_in),
    .clear_in    (cnt_clear),
    .step_in     (step_tick_in),
    .up_in       (cnt_up),
    .down_in     (cnt_down),
    .limit_in    (tx_in.limit),
    .count_out   (shape_count)
  );

  // drive index selection
  always_comb begin
    next_drive = pa_ramp_pkg::INDEX_ZERO;
    case (state)
      ST_IDLE: begin
        next_drive = pa_ramp_pkg::INDEX_ZERO;
      end
      ST_ON: begin
        if (is_ook) begin
          // zero symbol uses entry 0, one symbol entry 1
          next_drive = tx_in.symbol ? pa_ramp_pkg::INDEX_ONE
                                    : pa_ramp_pkg::INDEX_ZERO; // [RULE_05]
        end else if (is_ask) begin
          next_drive = shape_count; // [RULE_13]
        end else begin
          next_drive = tx_in.limit; // [RULE_02]
        end
      end
      default: begin
        // ramps walk through every entry up to the limit
        next_drive = shape_count; // [RULE_03]
      end
    endcase
  end

  // registered amplifier drive and status
  // code and index launch on one edge so they never disagree
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      pa_code_out     <= pa_ramp_pkg::ENTRY0_RESET;
      drive_index_out <= pa_ramp_pkg::INDEX_ZERO;
      ramp_busy_out   <= 1'b0;
      tx_on_out       <= 1'b0;
    end else if (clk_en_in) begin
      pa_code_out     <= drv_code; // [RULE_13]
      drive_index_out <= next_drive;
      ramp_busy_out   <= (state == ST_RAMP_UP) || (state == ST_RAMP_DOWN);
      tx_on_out       <= (state == ST_ON);
    end
  end

  // ---------------- checks ----------------

  // on-off keying picks entry 0 or 1 by symbol
  a_ook_levels: assert property ( // [RULE_05]
    @(posedge core_clk_in) disable iff (rst_in)
    (state == ST_ON && is_ook) |-> next_drive == {2'h0, tx_in.symbol})
    else $error("on-off keying used a wrong entry");

  // steady non-keyed level is the limit entry
  a_steady_limit: assert property ( // [RULE_02]
    @(posedge core_clk_in) disable iff (rst_in)
    (clk_en_in && state == ST_ON && tx_in.mode == pa_ramp_pkg::MOD_FSK)
    |=> drive_index_out == $past(tx_in.limit))
    else $error("steady level not at the limit entry");

  // a zero limit keeps the index at zero
  a_zero_limit: assert property ( // [RULE_04]
    @(posedge core_clk_in) disable iff (rst_in)
    (clk_en_in && tx_in.limit == 3'h0 && shape_count == 3'h0 && !is_ook)
    |=> shape_count == 3'h0)
    else $error("index left zero with zero limit");

  // a completed ramp up hands over to the steady level
  a_ramp_done: assert property ( // [RULE_03]
    @(posedge core_clk_in) disable iff (rst_in)
    (clk_en_in && state == ST_RAMP_UP && tx_in.tx_active && shape_count == tx_in.limit)
    |=> state == ST_ON)
    else $error("ramp up did not finish at the limit");

  // amplitude keying drives the code at the counter index
  a_ask_index: assert property ( // [RULE_13]
    @(posedge core_clk_in) disable iff (rst_in)
    (clk_en_in && state == ST_ON && is_ask)
    |=> (drive_index_out == $past(shape_count)) && (pa_code_out == $past(drv_code)))
    else $error("amplitude keying index not the counter");

  // idle always returns the counter to zero
  a_idle_zero: assert property ( // [RULE_16]
    @(posedge core_clk_in) disable iff (rst_in)
    (clk_en_in && state == ST_IDLE) |=> shape_count == 3'h0)
    else $error("counter not zero in idle");

  // a single write lands on entry zero
  a_single_idx: assert property ( // [RULE_06]
    @(posedge core_clk_in) disable iff (rst_in)
    (clk_en_in && access_in.wr && !access_in.start && !access_in.burst && !sleep_in)
    |=> u_store.mem[0] == $past(access_in.data))
    else $error("single write missed entry zero");

  // idle drives entry zero and nothing else
  a_idle_entry0: assert property ( // [RULE_16]
    @(posedge core_clk_in) disable iff (rst_in)
    (clk_en_in && state == ST_IDLE) |=> drive_index_out == 3'h0)
    else $error("idle drive index not zero");

  // ramp steps walk the table through the counter
  a_ramp_walk: assert property ( // [RULE_03]
    @(posedge core_clk_in) disable iff (rst_in)
    (state == ST_RAMP_UP || state == ST_RAMP_DOWN) |-> next_drive == shape_count)
    else $error("ramp index not the counter");

  // a finished ramp down returns to idle
  a_ramp_down_end: assert property ( // [RULE_16]
    @(posedge core_clk_in) disable iff (rst_in)
    (clk_en_in && state == ST_RAMP_DOWN && shape_count == 3'h0) |=> state == ST_IDLE)
    else $error("ramp down did not end in idle");

  // on-off keying stops without a ramp down
  a_ook_no_ramp: assert property ( // [RULE_03]
    @(posedge core_clk_in) disable iff (rst_in)
    (clk_en_in && state == ST_ON && is_ook && !tx_in.tx_active) |=> state == ST_IDLE)
    else $error("on-off keying ramped down");

endmodule : pa_index_limit_table_ramp_shaper

// *** pa_ramp_pkg.sv ***
package pa_ramp_pkg;

  // table geometry
  localparam int unsigned TABLE_DEPTH   = 8;        // power codes held
  localparam int unsigned INDEX_WIDTH   = 3;        // limit field and index width
  localparam int unsigned CODE_WIDTH    = 8;        // one power code

  // reset contents
  localparam logic [7:0]  ENTRY0_RESET  = 8'hC6;    // default code of entry 0
  localparam logic [7:0]  ENTRY_CLEARED = 8'h00;    // value of lost entries
  localparam logic [2:0]  INDEX_ZERO    = 3'h0;     // base table index
  localparam logic [2:0]  INDEX_ONE     = 3'h1;     // on-off keying high level index

  // shaping rate: counter steps per symbol period
  localparam int unsigned STEPS_PER_SYMBOL = 8;

  // modulation formats seen by the shaper
  typedef enum logic [1:0] {
    MOD_FSK,
    MOD_ASK,
    MOD_OOK
  } mod_mode_type;

  // one decoded byte event from the serial port front end
  typedef struct packed {
    logic       start;   // first cycle of an access (header seen)
    logic       burst;   // access is a burst access
    logic       wr;      // data byte written to the table
    logic       rd;      // data byte read from the table
    logic [7:0] data;    // write data
  } table_access_type;

  // transmit side configuration and symbol stream
  typedef struct packed {
    mod_mode_type mode;       // modulation format
    logic [2:0]   limit;      // power-index limit field
    logic         tx_active;  // transmission in progress
    logic         symbol;     // current transmitted symbol
  } tx_ctrl_type;

endpackage : pa_ramp_pkg

// *** pa_table_store.sv ***
`timescale 1ns/1ps
module pa_table_store #(
  parameter int unsigned DEPTH = pa_ramp_pkg::TABLE_DEPTH
) (
  input  wire logic       core_clk_in,   // block clock
  input  wire logic       rst_in,        // synchronous reset, active high
  input  wire logic       clk_en_in,     // freezes state while low
  input  wire logic       sleep_in,      // pulse: device enters sleep
  input  wire logic       wr_in,         // write strobe
  input  wire logic [2:0] wr_idx_in,     // write index
  input  wire logic [7:0] wr_data_in,    // write data
  input  wire logic [2:0] rd_idx_in,     // software read index
  input  wire logic [2:0] drv_idx_in,    // amplifier drive index
  output logic      [7:0] rd_code_out,   // code at software read index
  output logic      [7:0] drv_code_out   // code at drive index
);

  // power code storage
  logic [7:0] mem [DEPTH];

  // reset, sleep loss and writes
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      mem[0] <= pa_ramp_pkg::ENTRY0_RESET; // [RULE_08]
      for (int i = 1; i < DEPTH; i++) begin
        mem[i] <= pa_ramp_pkg::ENTRY_CLEARED;
      end
    end else if (clk_en_in) begin
      if (sleep_in) begin
        // all but entry 0 lose their contents
        for (int i = 1; i < DEPTH; i++) begin
          mem[i] <= pa_ramp_pkg::ENTRY_CLEARED; // [RULE_07]
        end
      end else if (wr_in) begin
        mem[wr_idx_in] <= wr_data_in; // [RULE_01]
      end
    end
  end

  // read ports are plain lookups
  assign rd_code_out  = mem[rd_idx_in];
  assign drv_code_out = mem[drv_idx_in];

  // entry 0 comes out of reset with the default code
  a_reset_default: assert property ( // [RULE_08]
    @(posedge core_clk_in) disable iff (rst_in)
    $past(rst_in) |-> mem[0] == pa_ramp_pkg::ENTRY0_RESET)
    else $error("entry 0 not at default after reset");

  // sleep clears upper entries and keeps entry 0
  a_sleep_keeps0: assert property ( // [RULE_07]
    @(posedge core_clk_in) disable iff (rst_in)
    (clk_en_in && sleep_in) |=>
      (mem[0] == $past(mem[0])) && (mem[1] == pa_ramp_pkg::ENTRY_CLEARED)
      && (mem[DEPTH-1] == pa_ramp_pkg::ENTRY_CLEARED))
    else $error("sleep did not clear upper entries or lost entry 0");

endmodule : pa_table_store

// *** pa_index_counter.sv ***
`timescale 1ns/1ps
module pa_index_counter #(
  parameter int unsigned WIDTH = pa_ramp_pkg::INDEX_WIDTH
) (
  input  wire logic             core_clk_in,  // block clock
  input  wire logic             rst_in,       // synchronous reset, active high
  input  wire logic             clk_en_in,    // freezes state while low
  input  wire logic             clear_in,     // force index to zero
  input  wire logic             step_in,      // eight pulses per symbol period
  input  wire logic             up_in,        // count toward the limit
  input  wire logic             down_in,      // count toward zero
  input  wire logic [WIDTH-1:0] limit_in,     // saturation ceiling
  output logic      [WIDTH-1:0] count_out     // current shaping index
);

  // saturating up/down counter, moves only on a step pulse or a clear
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      count_out <= '0;
    end else if (clk_en_in) begin
      if (clear_in) begin
        count_out <= '0; // [RULE_16]
      end else if (step_in) begin // [RULE_11]
        if (up_in && count_out < limit_in) begin
          count_out <= count_out + 1'b1; // [RULE_10]
        end else if (up_in && count_out > limit_in) begin
          count_out <= count_out - 1'b1; // limit lowered under the count
        end else if (down_in && count_out != '0) begin
          count_out <= count_out - 1'b1; // [RULE_10]
        end
      end
    end
  end

  // counting up holds at the limit, counting down holds at zero
  a_sat_hold: assert property ( // [RULE_12]
    @(posedge core_clk_in) disable iff (rst_in)
    (clk_en_in && !clear_in && step_in &&
     ((up_in && count_out == limit_in) || (down_in && !up_in && count_out == '0)))
    |=> count_out == $past(count_out))
    else $error("shaping counter wrapped past its bound");

  // no movement without a step pulse
  a_step_rate: assert property ( // [RULE_11]
    @(posedge core_clk_in) disable iff (rst_in)
    (clk_en_in && !clear_in && !step_in) |=> $stable(count_out))
    else $error("shaping counter moved without a step");

  // a one symbol steps the count up by exactly one
  a_count_up: assert property ( // [RULE_10]
    @(posedge core_clk_in) disable iff (rst_in)
    (clk_en_in && !clear_in && step_in && up_in && count_out < limit_in)
    |=> count_out == $past(count_out) + 1'b1)
    else $error("shaping counter did not increment");

endmodule : pa_index_counter

// *** pa_modulator_model.sv ***
`timescale 1ns/1ps
// modulator side: symbol timing and symbol stream fed to the shaper
module pa_modulator_model #(
  parameter int unsigned TICK_DIV = 4  // core cycles per shaping tick
) (
  input  wire logic       core_clk_in,  // block clock
  input  wire logic       rst_in,       // synchronous reset, active high
  input  wire logic [7:0] bits_in,      // symbol pattern, bit 0 sent first
  output logic            tick_out,     // shaping step pulse
  output logic            symbol_out,   // symbol now on air
  output logic      [2:0] sym_idx_out   // pattern position of that symbol
);
  int unsigned div;    // cycles since the last tick
  logic [2:0]  ticks;  // ticks spent in the current symbol

  // tick runs free from the crystal timing, not only during transmission
  always_ff @(posedge core_clk_in) begin
    if (rst_in || div == TICK_DIV - 1) begin
      div <= 0;
    end else begin
      div <= div + 1;
    end
    tick_out <= !rst_in && div == TICK_DIV - 1;
  end

  // a symbol lasts exactly eight ticks, so the shaper sees eight steps
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      ticks       <= 3'h0;
      sym_idx_out <= 3'h0;
    end else if (tick_out) begin
      ticks <= ticks + 3'h1;
      if (ticks == 3'h7) sym_idx_out <= sym_idx_out + 3'h1;
    end
  end

  // symbol held for its whole period
  assign symbol_out = bits_in[sym_idx_out];
endmodule : pa_modulator_model

// *** tb_pa_index_limit_table_ramp_shaper.sv ***
`timescale 1ns/1ps
module tb_pa_index_limit_table_ramp_shaper;
  logic                          core_clk;  // block clock
  logic                          rst;       // reset
  logic                          clk_en;    // clock enable
  logic                          sleep;     // sleep pulse
  pa_ramp_pkg::table_access_type acc;       // table access
  pa_ramp_pkg::mod_mode_type     mode;      // modulation format
  logic                    [2:0] limit;     // power-index limit
  logic                          tx_act;    // transmission on
  logic                          tick;      // shaping tick
  logic                          sym;       // current symbol
  logic                    [2:0] sym_idx;   // symbol position
  logic                    [7:0] bits;      // symbol pattern
  logic                    [7:0] pa_code;   // amplifier code
  logic                    [2:0] d_idx;     // drive index
  logic                          busy;      // ramp in progress
  logic                          tx_on;     // steady level
  logic                    [7:0] rd_data;   // read data
  logic                    [7:0] exp_tab [8]; // expected table
  logic                    [7:0] wr_vals [10]; // bytes to write
  logic                    [2:0] prev_idx;  // index one edge ago
  logic                    [2:0] idx_d2;    // index two edges ago
  logic                    [2:0] max_idx;   // highest index seen
  logic                          mon_on;    // monitor enable
  int                            bad_count; // mismatches
  int                            n_compared; // comparisons
  int                            seed;      // random seed
  int                            cycles;    // timeout counter

  pa_index_limit_table_ramp_shaper dut (
    .core_clk_in(core_clk), .rst_in(rst), .clk_en_in(clk_en), .access_in(acc),
    .tx_in({mode, limit, tx_act, sym}), .step_tick_in(tick), .sleep_in(sleep),
    .pa_code_out(pa_code), .drive_index_out(d_idx), .ramp_busy_out(busy),
    .tx_on_out(tx_on), .rd_data_out(rd_data));

  pa_modulator_model #(.TICK_DIV(4)) modem (
    .core_clk_in(core_clk), .rst_in(rst), .bits_in(bits), .tick_out(tick),
    .symbol_out(sym), .sym_idx_out(sym_idx));

  // clock, 5 ns period
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // compare one value and count it
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // verdict and end of run
  task automatic wrap_up();
    if (bad_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up

  // cut a hang short
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      wrap_up();
    end
  end

  // index moves one entry at a time, code follows a settled index
  always @(posedge core_clk) begin
    if (mon_on && d_idx !== prev_idx) begin
      chk({7'h0, (d_idx - prev_idx == 3'h1) || (prev_idx - d_idx == 3'h1)}, 8'h01, "step");
      if (d_idx > max_idx) max_idx <= d_idx;
    end
    if (mon_on && d_idx === prev_idx && prev_idx === idx_d2) chk(pa_code, exp_tab[d_idx], "code");
    prev_idx <= d_idx;
    idx_d2   <= prev_idx;
  end

  // wait n edges, then step just past the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc

  // ramp-safe codes only, never 61..6F
  function automatic logic [7:0] pick_code();
    if ($random(seed) % 4 == 0) return 8'h00;
    return {4'h3, 4'($random(seed))};
  endfunction : pick_code

  // shaping index after one whole symbol
  function automatic int ask_next(input int c, input logic s, input int lim);
    int n;
    n = pa_ramp_pkg::STEPS_PER_SYMBOL;
    if (s) return (c + n > lim) ? lim : c + n;
    return (c < n) ? 0 : c - n;
  endfunction : ask_next

  // header cycle of an access
  task automatic open_acc(input logic burst);
    acc.start = 1'b1;
    acc.burst = burst;
    cyc(1);
    acc.start = 1'b0;
  endtask : open_acc

  // write n bytes back to back
  task automatic write_seq(input logic burst, input int n);
    open_acc(burst);
    acc.wr = 1'b1;
    for (int i = 0; i < n; i++) begin
      acc.data = wr_vals[i];
      if (burst) exp_tab[i % 8] = wr_vals[i];
      else exp_tab[0] = wr_vals[i];
      cyc(1);
    end
    acc.wr = 1'b0;
  endtask : write_seq

  // burst read of all entries
  task automatic read_all();
    open_acc(1'b1);
    for (int i = 0; i < 8; i++) begin
      acc.rd = 1'b1;
      cyc(1);
      acc.rd = 1'b0;
      cyc(1);
      chk(rd_data, exp_tab[i], "table read");
    end
  endtask : read_all

  // wait for a symbol position
  task automatic wait_idx(input logic [2:0] v);
    for (int i = 0; i < 300 && sym_idx !== v; i++) cyc(1);
  endtask : wait_idx

  // end transmission, expect ramp down (none for on-off keying) to idle
  task automatic end_tx();
    tx_act = 1'b0;
    // wait past the steady level too, so a zero index at the drop is not taken as idle
    for (int i = 0; i < 400 && (busy !== 1'b0 || tx_on !== 1'b0 || d_idx !== 3'h0); i++) cyc(1);
    cyc(2);
    chk({6'h0, busy, tx_on}, 8'h00, "idle flags");
    chk({5'h0, d_idx}, 8'h00, "idle index");
    mon_on = 1'b0;
  endtask : end_tx

  // plain transmission with start and end ramps
  task automatic run_ramp(input logic [2:0] lim);
    logic [2:0] hold;
    mode = pa_ramp_pkg::MOD_FSK;
    limit = lim;
    max_idx = 3'h0;
    mon_on = 1'b1;
    tx_act = 1'b1;
    if (lim == 3'h7) begin
      // freeze mid-ramp: nothing moves while disabled
      cyc(6);
      clk_en = 1'b0;
      hold = d_idx;
      cyc(20);
      chk({5'h0, d_idx}, {5'h0, hold}, "frozen index");
      clk_en = 1'b1;
    end
    for (int i = 0; i < 400 && tx_on !== 1'b1; i++) cyc(1);
    cyc(3);
    chk({5'h0, d_idx}, {5'h0, lim}, "steady index");
    chk({5'h0, max_idx}, {5'h0, lim}, "ramp peak");
    chk(pa_code, exp_tab[lim], "steady code");
    end_tx();
  endtask : run_ramp

  // shaped or keyed transmission checked at each symbol end
  task automatic run_mod(input pa_ramp_pkg::mod_mode_type m, input logic [2:0] lim);
    int c;
    logic [2:0] last;
    logic [2:0] e;
    bits = 8'($random(seed)) & 8'hFC; // two zero symbols settle the counter
    mode = m;
    limit = lim;
    mon_on = 1'b1;
    wait_idx(3'h0);
    tx_act = 1'b1;
    wait_idx(3'h2);
    c = 0;
    for (int n = 0; n < 16; n++) begin
      last = sym_idx;
      wait_idx(last + 3'h1);
      c = ask_next(c, bits[last], lim);
      e = (m == pa_ramp_pkg::MOD_OOK) ? {2'h0, bits[last + 3'h1]} : 3'(c);
      cyc(3);
      chk({5'h0, d_idx}, {5'h0, e}, "shaped index");
      chk(pa_code, exp_tab[e], "shaped code");
    end
    end_tx();
  endtask : run_mod

  // main sequence
  initial begin
    seed = 61;
    rst = 1'b1;
    clk_en = 1'b1;
    sleep = 1'b0;
    acc = '0;
    mode = pa_ramp_pkg::MOD_FSK;
    limit = 3'h0;
    tx_act = 1'b0;
    bits = 8'h00;
    mon_on = 1'b0;
    max_idx = 3'h0;
    bad_count = 0;
    n_compared = 0;
    cycles = 0;
    for (int i = 0; i < 8; i++) exp_tab[i] = 8'h00;
    exp_tab[0] = 8'hC6;
    cyc(3);
    rst = 1'b0;
    chk(pa_code, 8'hC6, "reset code");
    read_all();
    // burst fill that wraps past the last entry
    for (int i = 0; i < 10; i++) wr_vals[i] = pick_code();
    write_seq(1'b1, 10);
    read_all();
    // single access reaches entry zero only
    wr_vals[0] = pick_code();
    wr_vals[1] = pick_code();
    write_seq(1'b0, 2);
    read_all();
    for (int lim = 0; lim < 8; lim++) run_ramp(3'(lim));
    run_mod(pa_ramp_pkg::MOD_ASK, 3'h7);
    run_mod(pa_ramp_pkg::MOD_ASK, 3'h3);
    run_mod(pa_ramp_pkg::MOD_OOK, 3'h7);
    // sleep keeps entry zero only
    sleep = 1'b1;
    cyc(1);
    sleep = 1'b0;
    for (int i = 1; i < 8; i++) exp_tab[i] = 8'h00;
    read_all();
    wrap_up();
  end
endmodule : tb_pa_index_limit_table_ramp_shaper
